// File: aesacc_top.sv
/*
 * AES-128 forward-cipher accelerator with chaining modes, counter,
 * trigger side effects, status events and two DMA channels; holds the
 * input FIFO module too. Assumes a single clock and a DMA controller
 * that counts transfers itself and pulses done after the last one.
 */
// Contract
// - Encrypt 128-bit blocks under a 128-bit key with standard AES-128.
// - Offer ECB, CBC-MAC, CBC, CTR, CFB, OFB and PCBC around one core.
// - Decrypt only in forward-cipher modes; refuse ECB, CBC, PCBC decryption.
// - Process two columns per cycle; ten rounds take twenty cycles.
// - Three preprocessing cycles precede rounds; 23 cycles per block.
// - Expand round keys on the fly and XOR each into the state.
// - Keep the loaded key across operations.
// - One 128-bit register is counter in CTR, next-block buffer otherwise.
// - Increment the counter in hardware over a configurable width.
// - Software sets source, triggers, DMA triggers, counter size, endianness, clearing.
// - Accesses can XOR data, clear events and raise DMA or cipher triggers.
// - Reset restores all registers; software then reprograms key and setup.
// - Four event sources: DMA A done, DMA B done, start, end.
// - Event output is the OR of masked status bits.
// - Each DMA channel has a request and done pair; device drives request.
// - Data-port address advances internally; DMA uses no increment here.
// - Optionally, writing the last input word starts a block.
// - Optionally, reading the last result word starts the next block.
// - Status shows busy during an operation and idle when done.
`timescale 1ns/1ps
`default_nettype none

module aesacc_fifo import aesacc_pkg::*; #(
	parameter int W = WORD_W,
	parameter int D = FIFO_DEPTH
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          push, pop;

	assign in_ready = cnt_reg != (AW+1)'(D);
	assign out_valid = cnt_reg != '0;
	assign out_data = mem[rp_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wp_next = push ? ((wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1) : wp_reg;
		rp_next = pop ? ((rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1) : rp_reg;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
		if (push) begin
			mem[wp_reg] <= in_data;
		end
	end
endmodule : aesacc_fifo

module aesacc_top import aesacc_pkg::*; (
	input  wire logic              CLK,
	input  wire logic              SRST,
	input  wire aesacc_cfg_t       CFG,
	input  wire logic              KEY_WR,
	input  wire logic [BLK_W-1:0]  KEY_IN,
	input  wire logic              START,
	input  wire logic              IN_WR,
	input  wire logic [1:0]        IN_IDX,
	input  wire logic [WORD_W-1:0] IN_DATA,
	input  wire logic              TEXT_WR,
	input  wire logic              TEXT_XOR,
	input  wire logic [1:0]        TEXT_IDX,
	input  wire logic [WORD_W-1:0] TEXT_DATA,
	input  wire logic              RD_STB,
	input  wire logic              RD_XBUF,
	input  wire logic [1:0]        RD_IDX,
	output logic [WORD_W-1:0]      RD_DATA,
	input  wire logic              DMAA_KICK,
	input  wire logic              DMAA_VALID,
	input  wire logic [WORD_W-1:0] DMAA_DATA,
	output logic                   DMAA_READY,
	output logic                   DMAA_REQ,
	input  wire logic              DMAA_DONE,
	input  wire logic              DMAB_RD,
	output logic [WORD_W-1:0]      DMAB_DATA,
	output logic                   DMAB_REQ,
	input  wire logic              DMAB_DONE,
	input  wire logic [IRQ_N-1:0]  IRQ_MASK,
	input  wire logic [IRQ_N-1:0]  IRQ_CLR,
	output logic [IRQ_N-1:0]       IRQ_RAW,
	output logic [IRQ_N-1:0]       MASKED_IRQ_STATUS,
	output logic                   EVENT,
	output logic                   BUSY,
	output logic                   BUF_FULL
);
	aesacc_state_t     st_reg, st_next;
	logic [4:0]        cnt_reg, cnt_next;
	logic [BLK_W-1:0]  s_reg, s_next, rk_reg, rk_next, key_reg, key_next;
	logic [BLK_W-1:0]  buf_reg, buf_next, text_reg, text_next, pl_reg, pl_next;
	logic [63:0]       tmp_reg, tmp_next;
	logic [7:0]        rcon_reg, rcon_next;
	logic              full_reg, full_next, pend_reg, pend_next;
	logic [1:0]        pa_reg, pa_next, pb_reg, pb_next;
	logic [IRQ_N-1:0]  irq_reg, irq_next, irq_set, irq_clr;
	logic [WORD_W-1:0] rd_reg, rd_next, db_reg, db_next;
	logic              reqa_reg, reqa_next, reqb_reg, reqb_next;
	logic              f_valid, f_ready, drain, wr_last, rd_last, trig, start_ok, mix;
	logic [WORD_W-1:0] f_data, w;
	logic [BLK_W-1:0]  nk, blk_in, ctr_mask;
	logic [WORD_W-1:0] colv [4];

	function automatic logic [7:0] xt(input logic [7:0] b);
		xt = {b[6:0], 1'b0} ^ (b[7] ? XT_POLY : 8'h00);
	endfunction : xt

	function automatic logic [31:0] bsw(input logic [31:0] d, input logic en);
		bsw = en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
	endfunction : bsw

	// Sub-bytes and shift-rows of one output column, mix-columns optional
	function automatic logic [31:0] col(input logic [127:0] s, input int c, input logic m);
		logic [7:0] b [4];
		for (int r = 0; r < 4; r++) begin
			b[r] = SBOX[s[127 - 8*(4*((c + r) % 4) + r) -: 8]];
		end
		col = {b[0], b[1], b[2], b[3]};
		if (m) begin
			for (int r = 0; r < 4; r++) begin
				col[31 - 8*r -: 8] = xt(b[r]) ^ xt(b[(r+1)%4]) ^ b[(r+1)%4]
					^ b[(r+2)%4] ^ b[(r+3)%4];
			end
		end
	endfunction : col

	function automatic logic [127:0] next_key(input logic [127:0] k, input logic [7:0] rc);
		logic [31:0] t, n0, n1, n2;
		t = {SBOX[k[23:16]] ^ rc, SBOX[k[15:8]], SBOX[k[7:0]], SBOX[k[31:24]]};
		n0 = k[127:96] ^ t;
		n1 = k[95:64] ^ n0;
		n2 = k[63:32] ^ n1;
		next_key = {n0, n1, n2, k[31:0] ^ n2};
	endfunction : next_key

	aesacc_fifo #(
		.W (WORD_W),
		.D (FIFO_DEPTH)
	) u_in_fifo (
		.clk       (CLK),
		.srst      (SRST),
		.in_valid  (DMAA_VALID),
		.in_data   (DMAA_DATA),
		.in_ready  (DMAA_READY),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (f_ready)
	);

	assign mix = cnt_reg < FINAL_FIRST;
	genvar gc;
	generate
		for (gc = 0; gc < 4; gc++) begin : g_col
			assign colv[gc] = col(s_reg, gc, mix);
		end
	endgenerate

	// A full buffer stalls the FIFO, so DMA back-pressure waits for the next start
	assign f_ready = !full_reg && !IN_WR;
	assign drain = f_valid && f_ready;
	assign wr_last = (IN_WR && IN_IDX == LAST_WORD) || (drain && pa_reg == LAST_WORD);
	assign rd_last = (RD_STB && RD_IDX == LAST_WORD) || (DMAB_RD && pb_reg == LAST_WORD);
	assign trig = START || pend_reg || (CFG.trg_wrbuf3 && wr_last)
		|| (CFG.trg_rdtxt3 && rd_last);
	assign start_ok = !(CFG.decrypt && (CFG.mode == MODE_ECB || CFG.mode == MODE_CBC
		|| CFG.mode == MODE_PCBC));

	always_comb begin
		case (CFG.ctr_size)
			CTR_8:   ctr_mask = {{120{1'b0}}, {8{1'b1}}};
			CTR_16:  ctr_mask = {{112{1'b0}}, {16{1'b1}}};
			CTR_32:  ctr_mask = {{96{1'b0}}, {32{1'b1}}};
			CTR_64:  ctr_mask = {{64{1'b0}}, {64{1'b1}}};
			default: ctr_mask = '1;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		s_next = s_reg;
		rk_next = rk_reg;
		tmp_next = tmp_reg;
		rcon_next = rcon_reg;
		key_next = KEY_WR ? KEY_IN : key_reg;
		buf_next = buf_reg;
		text_next = text_reg;
		pl_next = pl_reg;
		full_next = full_reg || wr_last;
		pend_next = pend_reg;
		pa_next = pa_reg;
		pb_next = pb_reg;
		rd_next = rd_reg;
		db_next = db_reg;
		reqa_next = DMAA_KICK;
		reqb_next = 1'b0;
		irq_set = '0;
		irq_set[IRQ_DMAA] = DMAA_DONE;
		irq_set[IRQ_DMAB] = DMAB_DONE;
		irq_clr = IRQ_CLR;
		irq_clr[IRQ_END] = IRQ_CLR[IRQ_END] || (CFG.clr_on_rd && rd_last);
		nk = next_key(rk_reg, rcon_reg);
		w = '0;
		if (IN_WR) begin
			buf_next[127 - 32*IN_IDX -: 32] = bsw(IN_DATA, CFG.byte_swap);
		end else if (drain) begin
			buf_next[127 - 32*pa_reg -: 32] = bsw(f_data, CFG.byte_swap);
			pa_next = pa_reg + 2'h1;
		end
		if (RD_STB) begin
			w = text_reg[127 - 32*RD_IDX -: 32];
			if (RD_XBUF) begin
				w = w ^ buf_reg[127 - 32*RD_IDX -: 32];
				text_next[127 - 32*RD_IDX -: 32] = w;
			end
			rd_next = bsw(w, CFG.byte_swap);
		end
		if (DMAB_RD) begin
			db_next = bsw(text_reg[127 - 32*pb_reg -: 32], CFG.byte_swap);
			pb_next = pb_reg + 2'h1;
		end
		if (TEXT_WR) begin
			w = bsw(TEXT_DATA, CFG.byte_swap);
			if (TEXT_XOR) begin
				w = w ^ text_next[127 - 32*TEXT_IDX -: 32];
			end
			text_next[127 - 32*TEXT_IDX -: 32] = w;
		end
		// The word whose access triggers the block must already be part of it
		case (CFG.mode)
			MODE_CBC, MODE_CBCMAC: blk_in = buf_next ^ text_next;
			MODE_CFB, MODE_OFB:    blk_in = text_next;
			MODE_PCBC:             blk_in = buf_next ^ text_next ^ pl_reg;
			default:               blk_in = buf_next;
		endcase
		case (st_reg)
			ST_IDLE: begin
				pend_next = 1'b0;
				if (trig && start_ok) begin
					s_next = blk_in;
					rk_next = key_reg;
					rcon_next = RCON_INIT;
					cnt_next = '0;
					st_next = ST_PRE;
					full_next = 1'b0;
					pl_next = buf_next;
					irq_set[IRQ_START] = 1'b1;
					reqa_next = DMAA_KICK || CFG.dmaa_on_start;
					if (CFG.mode == MODE_CTR) begin
						buf_next = (buf_next & ~ctr_mask)
							| ((buf_next + 128'h1) & ctr_mask);
					end
				end
			end
			ST_PRE: begin
				pend_next = pend_reg || trig;
				if (cnt_reg == '0) begin
					s_next = s_reg ^ rk_reg;
				end
				if (cnt_reg == PRE_LAST) begin
					st_next = ST_ROUND;
					cnt_next = '0;
				end else begin
					cnt_next = cnt_reg + 5'h01;
				end
			end
			ST_ROUND: begin
				pend_next = pend_reg || trig;
				cnt_next = cnt_reg + 5'h01;
				if (!cnt_reg[0]) begin
					rk_next = nk;
					tmp_next = {colv[0] ^ nk[127:96], colv[1] ^ nk[95:64]};
				end else begin
					s_next = {tmp_reg, colv[2] ^ rk_reg[63:32], colv[3] ^ rk_reg[31:0]};
					rcon_next = xt(rcon_reg);
				end
				if (cnt_reg == ROUND_LAST) begin
					st_next = ST_IDLE;
					text_next = s_next;
					pb_next = '0;
					irq_set[IRQ_END] = 1'b1;
					reqb_next = CFG.dmab_on_done;
				end
			end
			default: begin
				st_next = ST_IDLE;
			end
		endcase
		irq_next = (irq_reg & ~irq_clr) | irq_set;
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			st_reg <= ST_IDLE;
			cnt_reg <= '0;
			s_reg <= '0;
			rk_reg <= '0;
			tmp_reg <= '0;
			rcon_reg <= RCON_INIT;
			key_reg <= '0;
			buf_reg <= '0;
			text_reg <= '0;
			pl_reg <= '0;
			full_reg <= 1'b0;
			pend_reg <= 1'b0;
			pa_reg <= '0;
			pb_reg <= '0;
			irq_reg <= '0;
			rd_reg <= '0;
			db_reg <= '0;
			reqa_reg <= 1'b0;
			reqb_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			s_reg <= s_next;
			rk_reg <= rk_next;
			tmp_reg <= tmp_next;
			rcon_reg <= rcon_next;
			key_reg <= key_next;
			buf_reg <= buf_next;
			text_reg <= text_next;
			pl_reg <= pl_next;
			full_reg <= full_next;
			pend_reg <= pend_next;
			pa_reg <= pa_next;
			pb_reg <= pb_next;
			irq_reg <= irq_next;
			rd_reg <= rd_next;
			db_reg <= db_next;
			reqa_reg <= reqa_next;
			reqb_reg <= reqb_next;
		end
	end

	assign RD_DATA = rd_reg;
	assign DMAB_DATA = db_reg;
	assign DMAA_REQ = reqa_reg;
	assign DMAB_REQ = reqb_reg;
	assign IRQ_RAW = irq_reg;
	assign MASKED_IRQ_STATUS = irq_reg & IRQ_MASK;
	assign EVENT = |MASKED_IRQ_STATUS;
	assign BUSY = st_reg != ST_IDLE;
	assign BUF_FULL = full_reg;
endmodule : aesacc_top
`default_nettype wire

// File: aesacc_pkg.sv
/*
 * Shared constants and types of the block encryption accelerator:
 * S-box, modes, counter sizes, engine states, timing counts.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`default_nettype none
package aesacc_pkg;
	localparam int BLK_W = 128;
	localparam int WORD_W = 32;
	localparam int FIFO_DEPTH = 8;
	localparam int IRQ_N = 4;
	localparam int IRQ_DMAA = 0;
	localparam int IRQ_DMAB = 1;
	localparam int IRQ_START = 2;
	localparam int IRQ_END = 3;
	localparam logic [1:0] LAST_WORD = 2'h3;
	localparam logic [4:0] PRE_LAST = 5'h02;
	localparam logic [4:0] FINAL_FIRST = 5'h12;
	localparam logic [4:0] ROUND_LAST = 5'h13;
	localparam logic [7:0] RCON_INIT = 8'h01;
	localparam logic [7:0] XT_POLY = 8'h1B;

	typedef enum logic [2:0] {
		MODE_ECB = 3'h0, MODE_CBCMAC = 3'h1, MODE_CBC = 3'h2, MODE_CTR = 3'h3,
		MODE_CFB = 3'h4, MODE_OFB = 3'h5, MODE_PCBC = 3'h6
	} aesacc_mode_t;

	typedef enum logic [2:0] {
		CTR_8 = 3'h0, CTR_16 = 3'h1, CTR_32 = 3'h2, CTR_64 = 3'h3, CTR_128 = 3'h4
	} aesacc_ctr_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_PRE = 2'b01, ST_ROUND = 2'b10
	} aesacc_state_t;

	typedef struct packed {
		aesacc_mode_t mode;
		logic         decrypt;
		logic         trg_wrbuf3;
		logic         trg_rdtxt3;
		logic         dmaa_on_start;
		logic         dmab_on_done;
		aesacc_ctr_t  ctr_size;
		logic         byte_swap;
		logic         clr_on_rd;
	} aesacc_cfg_t;

	localparam logic [0:255][7:0] SBOX = {
		128'h637C777BF26B6FC53001672BFED7AB76, 128'hCA82C97DFA5947F0ADD4A2AF9CA472C0,
		128'hB7FD9326363FF7CC34A5E5F171D83115, 128'h04C723C31896059A071280E2EB27B275,
		128'h09832C1A1B6E5AA0523BD6B329E32F84, 128'h53D100ED20FCB15B6ACBBE394A4C58CF,
		128'hD0EFAAFB434D338545F9027F503C9FA8, 128'h51A3408F929D38F5BCB6DA2110FFF3D2,
		128'hCD0C13EC5F974417C4A77E3D645D1973, 128'h60814FDC222A908846EEB814DE5E0BDB,
		128'hE0323A0A4906245CC2D3AC629195E479, 128'hE7C8376D8DD54EA96C56F4EA657AAE08,
		128'hBA78252E1CA6B4C6E8DD741F4BBD8B8A, 128'h703EB5664803F60E613557B986C11D9E,
		128'hE1F8981169D98E949B1E87E9CE5528DF, 128'h8CA1890DBFE6426841992D0FB054BB16
	};
endpackage : aesacc_pkg
`default_nettype wire

// File: aesacc_chk.sv
/*
 * Port checker of the accelerator top: block timing, status events and
 * DMA requests. Assumes the single CLK domain and synchronous SRST.
 */
`timescale 1ns/1ps
`default_nettype none
module aesacc_chk import aesacc_pkg::*; (
	input wire logic             CLK,
	input wire logic             SRST,
	input wire aesacc_cfg_t      CFG,
	input wire logic             START,
	input wire logic             BUSY,
	input wire logic             DMAA_KICK,
	input wire logic             DMAA_REQ,
	input wire logic [IRQ_N-1:0] IRQ_MASK,
	input wire logic [IRQ_N-1:0] IRQ_CLR,
	input wire logic [IRQ_N-1:0] IRQ_RAW,
	input wire logic [IRQ_N-1:0] MASKED_IRQ_STATUS,
	input wire logic             EVENT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	logic refused;
	assign refused = CFG.decrypt && (CFG.mode inside {MODE_ECB, MODE_CBC, MODE_PCBC});

	a_event_or: assert property (EVENT == |MASKED_IRQ_STATUS)
		else $error("event differs from OR of masked status");
	a_mask_gate: assert property (MASKED_IRQ_STATUS == (IRQ_RAW & IRQ_MASK))
		else $error("masked status is not raw and mask");
	a_busy_span: assert property ($rose(BUSY) |->
		BUSY[*8] ##1 BUSY[*8] ##1 BUSY[*7] ##1 !BUSY)
		else $error("block did not take 23 cycles");
	a_start_flag: assert property ($rose(BUSY) |-> IRQ_RAW[IRQ_START])
		else $error("start event missing");
	a_end_flag: assert property ($fell(BUSY) |-> IRQ_RAW[IRQ_END])
		else $error("end event missing");
	// The end flag may also fall through a clearing read of the last result word
	a_raw_sticky: assert property (1'b1 |=>
		(($past(IRQ_RAW) & ~$past(IRQ_CLR) & ~{$past(CFG.clr_on_rd), 3'h0}
		& ~IRQ_RAW) == 4'h0))
		else $error("raw status dropped without clear");
	a_take_start: assert property (START && !BUSY && !refused |=> BUSY)
		else $error("start not taken while idle");
	a_refuse_dec: assert property (START && !BUSY && refused |=> !BUSY)
		else $error("unsupported decryption started");
	a_kick_req: assert property (DMAA_KICK |=> DMAA_REQ)
		else $error("kick gave no input request");
	a_start_req: assert property ($rose(BUSY) && CFG.dmaa_on_start |-> DMAA_REQ)
		else $error("start gave no input request");
endmodule : aesacc_chk

bind aesacc_top aesacc_chk aesacc_chk_inst (.CLK(CLK), .SRST(SRST), .CFG(CFG),
	.START(START), .BUSY(BUSY), .DMAA_KICK(DMAA_KICK), .DMAA_REQ(DMAA_REQ),
	.IRQ_MASK(IRQ_MASK), .IRQ_CLR(IRQ_CLR), .IRQ_RAW(IRQ_RAW),
	.MASKED_IRQ_STATUS(MASKED_IRQ_STATUS), .EVENT(EVENT));
`default_nettype wire

// File: aesacc_dma_model.sv
/*
 * Behavioural DMA controller feeding the input channel.
 * Assumes the bench sets the total word count before a request arrives.
 */
`timescale 1ns/1ps
`default_nettype none
module aesacc_dma_model import aesacc_pkg::*; (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              req,
	input  wire logic              slow,
	input  wire logic [4:0]        total,
	input  wire logic [WORD_W-1:0] base,
	input  wire logic              ready,
	output logic                   valid,
	output logic [WORD_W-1:0]      data,
	output logic                   done
);
	localparam int SERVED_CH = 4;
	logic [4:0] sent;
	logic       run;
	logic       ph;
	always_ff @(posedge clk) begin
		done <= 1'b0;
		ph <= ~ph;
		if (srst) begin
			run <= 1'b0;
			valid <= 1'b0;
			sent <= 5'h00;
			ph <= 1'b0;
			data <= 32'h00000000;
		end else begin
			if (req && !run) begin
				run <= 1'b1;
				sent <= 5'h00;
			end
			if (valid && ready) begin
				valid <= 1'b0;
				// Released line shows the inverse so stale data cannot pass
				data <= ~data;
				sent <= 5'(sent + 1);
				if (5'(sent + 1) == total) begin
					run <= 1'b0;
					done <= 1'b1;
				end
			end else if (run && !valid && !(slow && ph)) begin
				valid <= 1'b1;
				data <= base + WORD_W'(sent);
			end
		end
	end
endmodule : aesacc_dma_model
`default_nettype wire

// File: aesacc_tb_top.sv
/*
 * Self-checking bench: known-answer blocks, modes, triggers, events and
 * DMA traffic. Assumes the DMA model and checker files are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module aesacc_tb_top import aesacc_pkg::*;;
	localparam logic [BLK_W-1:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
	localparam logic [BLK_W-1:0] PT  = 128'h00112233445566778899AABBCCDDEEFF;
	localparam logic [BLK_W-1:0] CT  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
	logic CLK = 1'b0;
	logic SRST, KEY_WR, START, IN_WR, TEXT_WR, TEXT_XOR, RD_STB, RD_XBUF, DMAA_KICK;
	logic DMAB_RD, DMAB_DONE, DMAA_VALID, DMAA_READY, DMAA_REQ, DMAA_DONE, DMAB_REQ;
	logic EVENT, BUSY, BUF_FULL, slow;
	aesacc_cfg_t CFG;
	logic [1:0] IN_IDX, TEXT_IDX, RD_IDX;
	logic [WORD_W-1:0] IN_DATA, TEXT_DATA, RD_DATA, DMAA_DATA, DMAB_DATA, base;
	logic [IRQ_N-1:0] IRQ_MASK, IRQ_CLR, IRQ_RAW, MASKED_IRQ_STATUS;
	logic [BLK_W-1:0] blk, r, s;
	int fail_count, samples_checked, seed, n;
	aesacc_mode_t mlist [3] = '{MODE_CBCMAC, MODE_CFB, MODE_PCBC};
	aesacc_mode_t dlist [3] = '{MODE_ECB, MODE_CBC, MODE_PCBC};

	aesacc_top aesacc_top_inst (.CLK(CLK), .SRST(SRST), .CFG(CFG), .KEY_WR(KEY_WR),
		.KEY_IN(KEY), .START(START), .IN_WR(IN_WR), .IN_IDX(IN_IDX), .IN_DATA(IN_DATA),
		.TEXT_WR(TEXT_WR), .TEXT_XOR(TEXT_XOR), .TEXT_IDX(TEXT_IDX),
		.TEXT_DATA(TEXT_DATA),
		.RD_STB(RD_STB), .RD_XBUF(RD_XBUF), .RD_IDX(RD_IDX), .RD_DATA(RD_DATA),
		.DMAA_KICK(DMAA_KICK), .DMAA_VALID(DMAA_VALID), .DMAA_DATA(DMAA_DATA),
		.DMAA_READY(DMAA_READY), .DMAA_REQ(DMAA_REQ), .DMAA_DONE(DMAA_DONE),
		.DMAB_RD(DMAB_RD), .DMAB_DATA(DMAB_DATA), .DMAB_REQ(DMAB_REQ),
		.DMAB_DONE(DMAB_DONE), .IRQ_MASK(IRQ_MASK), .IRQ_CLR(IRQ_CLR), .IRQ_RAW(IRQ_RAW),
		.MASKED_IRQ_STATUS(MASKED_IRQ_STATUS), .EVENT(EVENT), .BUSY(BUSY),
		.BUF_FULL(BUF_FULL));
	aesacc_dma_model aesacc_dma_model_inst (.clk(CLK), .srst(SRST), .req(DMAA_REQ),
		.slow(slow), .total(5'h0C), .base(base), .ready(DMAA_READY),
		.valid(DMAA_VALID), .data(DMAA_DATA), .done(DMAA_DONE));

	always #10 CLK = ~CLK;

	task automatic tick();
		@(posedge CLK);
		#1;
	endtask : tick

	task automatic test_done();
		if (fail_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic go(input string w);
		START = 1'b1;
		tick();
		START = 1'b0;
		n = 0;
		while (BUSY === 1'b1 && n < 40) begin
			tick();
			n++;
		end
		if (n >= 40) begin
			fail_count++;
			test_done();
		end
		`CHK(w, 23, n)
	endtask : go

	// One strobe held over four words, so no signal is set twice in a step
	task automatic loadbuf(input logic [BLK_W-1:0] b);
		IN_WR = 1'b1;
		for (int i = 0; i < 4; i++) begin
			IN_IDX = 2'(i);
			IN_DATA = b[BLK_W-1-32*i -: 32];
			tick();
		end
		IN_WR = 1'b0;
	endtask : loadbuf

	task automatic wtxt(input logic [BLK_W-1:0] b, input logic x);
		TEXT_WR = 1'b1;
		TEXT_XOR = x;
		for (int i = 0; i < 4; i++) begin
			TEXT_IDX = 2'(i);
			TEXT_DATA = b[BLK_W-1-32*i -: 32];
			tick();
		end
		TEXT_WR = 1'b0;
	endtask : wtxt

	task automatic rdblk(input logic xb);
		RD_XBUF = xb;
		RD_STB = 1'b1;
		for (int i = 0; i < 4; i++) begin
			RD_IDX = 2'(i);
			tick();
			blk[BLK_W-1-32*i -: 32] = RD_DATA;
		end
		RD_STB = 1'b0;
	endtask : rdblk

	// Byte order reversed inside each 32-bit word
	function automatic logic [BLK_W-1:0] bswap128(input logic [BLK_W-1:0] b);
		for (int i = 0; i < 16; i++) begin
			bswap128[8*i +: 8] = b[8*(4*(i/4) + 3 - i%4) +: 8];
		end
	endfunction : bswap128

	initial begin
		seed = 80049;
		{KEY_WR, START, IN_WR, TEXT_WR, TEXT_XOR, RD_STB, RD_XBUF, DMAA_KICK} = '0;
		{DMAB_RD, DMAB_DONE, IN_IDX, TEXT_IDX, RD_IDX, IN_DATA, TEXT_DATA} = '0;
		{IRQ_MASK, IRQ_CLR, base, CFG} = '0;
		slow = 1'b1;
		SRST = 1'b1;
		repeat (10) tick();
		SRST = 1'b0;
		`CHK("reset", 9'h001, {BUSY, IRQ_RAW, EVENT, DMAA_REQ, DMAB_REQ, DMAA_READY})
		KEY_WR = 1'b1;
		tick();
		KEY_WR = 1'b0;
		loadbuf(PT);
		`CHK("buf full", 1'b1, BUF_FULL)
		go("ecb span");
		rdblk(1'b0);
		`CHK("ecb", CT, blk)
		`CHK("raw", 4'hC, IRQ_RAW)
		IRQ_MASK = 4'h8;
		DMAB_DONE = 1'b1;
		tick();
		DMAB_DONE = 1'b0;
		`CHK("masked", 4'h8, MASKED_IRQ_STATUS)
		`CHK("event", 1'b1, EVENT)
		IRQ_CLR = 4'hC;
		tick();
		IRQ_CLR = 4'h0;
		`CHK("cleared", 4'h2, IRQ_RAW)
		`CHK("no event", 1'b0, EVENT)
		// A stale last word shows whether the triggering write joins the block
		loadbuf(~PT);
		CFG.trg_wrbuf3 = 1'b1;
		loadbuf(PT);
		START = 1'b0;
		CFG.trg_wrbuf3 = 1'b0;
		n = 0;
		while (BUSY === 1'b1 && n < 40) begin
			tick();
			n++;
		end
		`CHK("wrbuf3 span", 23, n)
		rdblk(1'b0);
		`CHK("kept key", CT, blk)
		wtxt(PT, 1'b0);
		CFG.mode = MODE_OFB;
		go("ofb span");
		rdblk(1'b0);
		`CHK("ofb", CT, blk)
		wtxt('0, 1'b0);
		CFG.mode = MODE_CBC;
		go("cbc span");
		rdblk(1'b0);
		`CHK("cbc", CT, blk)
		loadbuf({PT[BLK_W-1:8], 8'hFE});
		CFG.mode = MODE_CTR;
		CFG.ctr_size = CTR_8;
		go("ctr span");
		CFG.mode = MODE_ECB;
		go("after ctr");
		rdblk(1'b0);
		`CHK("counter", CT, blk)
		foreach (mlist[i]) begin
			CFG.mode = mlist[i];
			go("mode span");
		end
		CFG.decrypt = 1'b1;
		foreach (dlist[i]) begin
			CFG.mode = dlist[i];
			START = 1'b1;
			tick();
			START = 1'b0;
			tick();
			`CHK("refused", 1'b0, BUSY)
		end
		CFG.mode = MODE_CFB;
		go("fwd decrypt");
		CFG.decrypt = 1'b0;
		CFG.mode = MODE_ECB;
		CFG.trg_rdtxt3 = 1'b1;
		rdblk(1'b0);
		CFG.trg_rdtxt3 = 1'b0;
		`CHK("rdtxt3 start", 1'b1, BUSY)
		repeat (25) tick();
		r = {$random(seed), $random(seed), $random(seed), $random(seed)};
		s = {$random(seed), $random(seed), $random(seed), $random(seed)};
		wtxt(r, 1'b0);
		tick();
		wtxt(s, 1'b1);
		CFG.clr_on_rd = 1'b1;
		rdblk(1'b0);
		CFG.clr_on_rd = 1'b0;
		`CHK("text xor", r ^ s, blk)
		`CHK("read clears end", 1'b0, IRQ_RAW[IRQ_END])
		CFG.byte_swap = 1'b1;
		wtxt(r, 1'b0);
		CFG.byte_swap = 1'b0;
		rdblk(1'b0);
		`CHK("swap", bswap128(r), blk)
		base = $random(seed);
		CFG.dmaa_on_start = 1'b1;
		CFG.dmab_on_done = 1'b1;
		loadbuf(PT);
		go("dma span");
		`CHK("out req", 1'b1, DMAB_REQ)
		CFG.dmaa_on_start = 1'b0;
		n = 0;
		while (DMAA_DONE !== 1'b1 && n < 200) begin
			tick();
			n++;
		end
		if (n >= 200) begin
			fail_count++;
			test_done();
		end
		tick();
		`CHK("fifo full", 1'b0, DMAA_READY)
		`CHK("dma done", 1'b1, IRQ_RAW[IRQ_DMAA])
		DMAB_RD = 1'b1;
		for (int i = 0; i < 4; i++) begin
			tick();
			blk[BLK_W-1-32*i -: 32] = DMAB_DATA;
		end
		DMAB_RD = 1'b0;
		`CHK("dmab", CT, blk)
		rdblk(1'b1);
		`CHK("xbuf", CT ^ {base, base + 32'h1, base + 32'h2, base + 32'h3}, blk)
		go("drain one");
		go("drain two");
		`CHK("drained", 1'b1, DMAA_READY)
		DMAA_KICK = 1'b1;
		tick();
		DMAA_KICK = 1'b0;
		`CHK("kick", 1'b1, DMAA_REQ)
		test_done();
	end
endmodule : aesacc_tb_top
`default_nettype wire
